// file: verilog/sfsf_status.sv
// serial status register with read-then-clear flags and receive gating
// =====================================================
// Function
// RULE_01: one 16-bit readable writable status register
// RULE_02: software writes never set any flag
// RULE_03: clear by writing 0 after reading 1
// RULE_04: transmit end and error indicators read-only
// RULE_05: bits 15 to 10 read zero
// RULE_06: overrun sets when full FIFO receives
// RULE_07: overrun only valid in asynchronous mode
// RULE_08: overrun clears on reset or read-clear
// RULE_09: receive disable leaves overrun unchanged
// RULE_10: overrun keeps FIFO, drops new, halts
// RULE_11: count match sets when count equals setting
// RULE_12: count match clears on reset or read-clear
// RULE_13: receive error marks framing or parity
// RULE_14: error on zero stop or parity mismatch
// RULE_15: only first stop bit is checked
// RULE_16: error clears; bad character still stored
// RULE_17: unread write of 0 leaves flag
// RULE_18: reserved and read-only writes change nothing
`default_nettype none
module sfsf_status (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register port
    input wire logic [sfsf_pkg::ADDR_W-1:0] addr_in,
    input wire logic [sfsf_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [sfsf_pkg::DATA_W-1:0] rd_data_out,
    // receive side
    input wire logic rx_done_in,
    input wire sfsf_pkg::sfsf_rx_char_t rx_char_in,
    input wire logic rx_fifo_full_in,
    output logic rx_store_out,
    output sfsf_pkg::sfsf_store_t rx_store_data_out,
    // transmit side
    input wire logic tx_item_done_in,
    // flag sources and indicators of the neighbouring datapath
    input wire sfsf_pkg::sfsf_ext_set_t ext_set_in,
    input wire sfsf_pkg::sfsf_ro_t ro_in,
    // control levels for the datapath
    output logic receive_enable_out,
    output logic overrun_error_flag_out
);
    import sfsf_pkg::*;

    // =====================================================
    // decode
    logic wr_status;
    logic rd_status;
    logic wr_control;
    logic wr_stopcnt;
    assign wr_status = wr_in && (addr_in == STATUS_ADDR);
    assign rd_status = rd_in && (addr_in == STATUS_ADDR);
    assign wr_control = wr_in && (addr_in == CONTROL_ADDR);
    assign wr_stopcnt = wr_in && (addr_in == STOPCNT_ADDR);

    // =====================================================
    // control and transmit stop count
    logic [CTRL_W-1:0] control_r;
    logic [CNT_W-1:0] transmit_stop_count_r;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            control_r <= CTRL_RST;
        end else if (wr_control) begin
            control_r <= wr_data_in[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            transmit_stop_count_r <= STOPCNT_RST;
        end else if (wr_stopcnt) begin
            transmit_stop_count_r <= wr_data_in[CNT_W-1:0];
        end
    end

    logic async_mode;
    assign async_mode = !control_r[CTRL_SYNC];

    // =====================================================
    // receive acceptance
    logic [DATA_W-1:0] flag_r;
    logic overrun;
    logic rx_take;
    logic rx_accept;
    logic rx_overrun_evt;
    logic stop_bad;
    logic par_bad;
    logic rx_err_evt;
    assign overrun = flag_r[OVERRUN_BIT];
    assign rx_take = rx_done_in && control_r[CTRL_RX_EN];
    // a set overrun flag halts reception; full FIFO drops the new one
    assign rx_overrun_evt = rx_take && !overrun && rx_fifo_full_in
        && async_mode; // [RULE_06] [RULE_07]
    assign rx_accept = rx_take && !overrun && !rx_fifo_full_in; // [RULE_10]
    // only the first stop bit is carried and checked
    assign stop_bad = !rx_char_in.stop; // [RULE_14] [RULE_15]
    assign par_bad = control_r[CTRL_PAR_EN]
        && ((^rx_char_in.data ^ rx_char_in.parity)
        != control_r[CTRL_PAR_ODD]); // [RULE_14]
    assign rx_err_evt = rx_accept && async_mode
        && (stop_bad || par_bad); // [RULE_13] [RULE_16]

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_store_out <= 1'b0;
        end else begin
            rx_store_out <= rx_accept; // [RULE_16]
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_store_data_out <= '0;
        end else if (rx_accept) begin
            rx_store_data_out.data <= rx_char_in.data;
            rx_store_data_out.framing_err <= stop_bad && async_mode;
            rx_store_data_out.parity_err <= par_bad && async_mode;
        end
    end

    // =====================================================
    // transmit count match
    logic [CNT_W-1:0] tx_count_r;
    logic [CNT_W-1:0] tx_count_nxt;
    logic tx_match_evt;
    assign tx_count_nxt = tx_count_r + 8'h01;
    assign tx_match_evt = tx_item_done_in
        && (tx_count_nxt == transmit_stop_count_r); // [RULE_11]

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || wr_stopcnt) begin
            tx_count_r <= TXCNT_RST;
        end else if (tx_match_evt) begin
            tx_count_r <= TXCNT_RST;
        end else if (tx_item_done_in) begin
            tx_count_r <= tx_count_nxt;
        end
    end

    // =====================================================
    // clearable flags
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] armed_r;
    logic [DATA_W-1:0] clr_vec;
    always_comb begin
        set_vec = '0;
        set_vec[OVERRUN_BIT] = rx_overrun_evt;
        set_vec[TXMATCH_BIT] = tx_match_evt;
        set_vec[RXERR_BIT] = rx_err_evt;
        set_vec[TXTHR_BIT] = ext_set_in.txfifo_thr;
        set_vec[BREAK_BIT] = ext_set_in.line_break;
        set_vec[RXFULL_BIT] = ext_set_in.rxfifo_full;
        set_vec[READY_BIT] = ext_set_in.data_ready;
    end
    // a 0 clears only where that flag was seen as 1
    assign clr_vec = {DATA_W{wr_status}} & ~wr_data_in & armed_r
        & CLR_MASK; // [RULE_03] [RULE_17] [RULE_18]

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_r <= STATUS_RST; // [RULE_08] [RULE_12] [RULE_16]
        end else begin
            for (int i = 0; i < DATA_W; i++) begin
                if (CLR_MASK[i] && set_vec[i]) begin
                    flag_r[i] <= 1'b1; // set wins over clear [RULE_02]
                end else if (clr_vec[i]) begin
                    flag_r[i] <= 1'b0; // [RULE_03] [RULE_08] [RULE_12]
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            armed_r <= '0;
        end else begin
            for (int i = 0; i < DATA_W; i++) begin
                if (clr_vec[i]) begin
                    armed_r[i] <= 1'b0;
                end else if (rd_status && flag_r[i] && CLR_MASK[i]) begin
                    armed_r[i] <= 1'b1; // [RULE_03]
                end
            end
        end
    end

    // =====================================================
    // read path
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] rd_nxt;
    always_comb begin
        status_view = flag_r & CLR_MASK; // [RULE_05]
        status_view[TXEND_BIT] = ro_in.tx_end; // [RULE_04]
        status_view[FRAMING_BIT] = ro_in.framing; // [RULE_04]
        status_view[PARITY_BIT] = ro_in.parity; // [RULE_04]
    end

    always_comb begin
        rd_nxt = '0;
        if (rd_in) begin
            case (addr_in)
                STATUS_ADDR: rd_nxt = status_view; // [RULE_01]
                CONTROL_ADDR: rd_nxt[CTRL_W-1:0] = control_r;
                STOPCNT_ADDR: rd_nxt[CNT_W-1:0] = transmit_stop_count_r;
                default: rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= rd_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            receive_enable_out <= 1'b0;
            overrun_error_flag_out <= 1'b0;
        end else begin
            receive_enable_out <= control_r[CTRL_RX_EN];
            overrun_error_flag_out <= set_vec[OVERRUN_BIT]
                || (overrun && !clr_vec[OVERRUN_BIT]); // [RULE_09]
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    rsvd_read_zero_a: assert property ( // [RULE_05]
        $past(rd_in) |-> rd_data_out[DATA_W-1:RSVD_LSB] == '0)
        else $error("reserved status bits read nonzero");

    no_write_set_a: assert property ( // [RULE_02]
        ((flag_r & ~$past(flag_r)) & ~$past(set_vec)) == '0)
        else $error("status flag rose without hardware event");

    clear_needs_read_a: assert property ( // [RULE_03] [RULE_17]
        $fell(flag_r[RXERR_BIT]) |->
        $past(wr_status && !wr_data_in[RXERR_BIT] && armed_r[RXERR_BIT]))
        else $error("receive error cleared without prior read");

    overrun_set_a: assert property ( // [RULE_06]
        rx_take && !overrun && rx_fifo_full_in && async_mode
        |=> overrun && !rx_store_out)
        else $error("overrun not raised on full receive");

    overrun_keep_a: assert property ( // [RULE_09]
        overrun && !wr_status ##1 !control_r[CTRL_RX_EN] |-> overrun)
        else $error("overrun changed without software clear");

    overrun_halt_a: assert property ( // [RULE_10]
        overrun && rx_done_in |=> !rx_store_out)
        else $error("reception continued while overrun set");

    count_match_a: assert property ( // [RULE_11]
        tx_item_done_in && tx_count_nxt == transmit_stop_count_r
        |=> flag_r[TXMATCH_BIT])
        else $error("count match flag not raised");

    bad_stop_a: assert property ( // [RULE_14] [RULE_16]
        rx_accept && async_mode && !rx_char_in.stop
        |=> flag_r[RXERR_BIT] && rx_store_out
        && rx_store_data_out.framing_err)
        else $error("framing error not flagged or char lost");

    ro_track_a: assert property ( // [RULE_04]
        rd_status ##1 1'b1 |->
        rd_data_out[TXEND_BIT] == $past(ro_in.tx_end))
        else $error("transmit end bit not read-only view");

    reset_clear_a: assert property ( // [RULE_08] [RULE_12]
        disable iff (1'b0)
        $past(sys_rst_in) |-> flag_r == STATUS_RST)
        else $error("flags not cleared by reset");

    bad_parity_a: assert property ( // [RULE_14] [RULE_16]
        rx_accept && async_mode && par_bad
        |=> flag_r[RXERR_BIT] && rx_store_out && rx_store_data_out.parity_err)
        else $error("parity error not flagged or char lost");

    sync_no_error_a: assert property ( // [RULE_07] [RULE_13]
        rx_accept && !async_mode
        |=> !rx_store_data_out.framing_err && !rx_store_data_out.parity_err)
        else $error("error bits marked in synchronous mode");

    read_idle_zero_a: assert property ( // [RULE_01]
        !$past(rd_in) |-> rd_data_out == '0)
        else $error("read data not zero outside read answer");

    read_clear_c: cover property (
        rd_status && flag_r[OVERRUN_BIT] ##1 wr_status
        && !wr_data_in[OVERRUN_BIT] ##1 !overrun);
    set_beats_clear_c: cover property (
        clr_vec[RXERR_BIT] && set_vec[RXERR_BIT]);
    count_match_c: cover property (tx_match_evt);
    parity_err_c: cover property (rx_accept && par_bad);

endmodule : sfsf_status
`default_nettype wire

// file: inc/sfsf_pkg.sv
// constants, field layout and carrier types of the serial status flag block
`default_nettype none
package sfsf_pkg;
    // =====================================================
    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;
    localparam int CTRL_W = 4;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] STOPCNT_ADDR = 8'h08;
    // =====================================================
    // serial_status field positions
    localparam int OVERRUN_BIT = 9;
    localparam int TXMATCH_BIT = 8;
    localparam int RXERR_BIT = 7;
    localparam int TXEND_BIT = 6;
    localparam int TXTHR_BIT = 5;
    localparam int BREAK_BIT = 4;
    localparam int FRAMING_BIT = 3;
    localparam int PARITY_BIT = 2;
    localparam int RXFULL_BIT = 1;
    localparam int READY_BIT = 0;
    localparam int RSVD_LSB = 10;
    localparam logic [DATA_W-1:0] CLR_MASK = 16'h03b3;
    localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;
    // =====================================================
    // serial_control field positions and reset values
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_SYNC = 1;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_PAR_ODD = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [CNT_W-1:0] STOPCNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] TXCNT_RST = 8'h00;
    // =====================================================
    // carrier types
    typedef struct packed {
        logic [7:0] data;
        logic parity;
        logic stop;
    } sfsf_rx_char_t;
    typedef struct packed {
        logic [7:0] data;
        logic framing_err;
        logic parity_err;
    } sfsf_store_t;
    typedef struct packed {
        logic txfifo_thr;
        logic line_break;
        logic rxfifo_full;
        logic data_ready;
    } sfsf_ext_set_t;
    typedef struct packed {
        logic tx_end;
        logic framing;
        logic parity;
    } sfsf_ro_t;
endpackage : sfsf_pkg
`default_nettype wire

// file: verif/sfsf_peer.sv
// remote serial transmitter model that hands completed characters to the block
`default_nettype none
module sfsf_peer (
    // clock
    input wire logic clk_in,
    // completed character
    output logic rx_done_out,
    output sfsf_pkg::sfsf_rx_char_t rx_char_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sfsf_pkg::*;
    initial begin
        rx_done_out = 1'b0;
        rx_char_out = '0;
    end
    // one character per call; only the first stop bit travels
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk_in);
        rx_done_out <= 1'b1;
        rx_char_out <= {d, p, s};
        @(posedge clk_in);
        rx_done_out <= 1'b0;
        // stale character is not left on the lines
        rx_char_out <= ~{d, p, s};
    endtask : send
endmodule : sfsf_peer
`default_nettype wire

// file: verif/tb.sv
// self-checking bench of the serial status flag block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfsf_pkg::*;
    logic clk_in, sys_rst_in, wr_in, rd_in, rx_fifo_full_in, tx_item_done_in, rx_done_in;
    logic rx_store_out, receive_enable_out, overrun_error_flag_out;
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] wr_data_in, rd_data_out;
    logic [DATA_W-1:0] st = 16'h0000;
    logic [DATA_W-1:0] ro_bits;
    logic rd_seen = 1'b0;
    sfsf_rx_char_t rx_char_in;
    sfsf_store_t rx_store_data_out;
    sfsf_ext_set_t ext_set_in;
    sfsf_ro_t ro_in;
    logic [DATA_W-1:0] rd_q[$];
    sfsf_store_t st_q[$];
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    // =====================================================
    // clock, design and far side
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    sfsf_status sfsf_status_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .rx_done_in(rx_done_in), .rx_char_in(rx_char_in),
        .rx_fifo_full_in(rx_fifo_full_in), .rx_store_out(rx_store_out),
        .rx_store_data_out(rx_store_data_out), .tx_item_done_in(tx_item_done_in),
        .ext_set_in(ext_set_in), .ro_in(ro_in), .receive_enable_out(receive_enable_out),
        .overrun_error_flag_out(overrun_error_flag_out));
    sfsf_peer sfsf_peer_inst (.clk_in(clk_in), .rx_done_out(rx_done_in),
        .rx_char_out(rx_char_in));
    // =====================================================
    // checking and closing
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // oldest note is compared whenever read data or a stored character appears
    always @(posedge clk_in) begin
        if (rd_seen) begin
            chk(rd_data_out, rd_q.pop_front());
        end else if (!sys_rst_in) begin
            chk(rd_data_out, 16'h0000);
        end
        if (rx_store_out) begin
            chk({6'h00, rx_store_data_out}, st_q.size() > 0 ? {6'h00, st_q.pop_front()} : 16'hffff);
        end
        rd_seen <= rd_in;
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            end_of_test();
        end
    end
    // =====================================================
    // register port and event drivers
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask : rd
    task automatic rs();
        rd(STATUS_ADDR, st | ro_bits);
    endtask : rs
    // read arms every set flag, then a write of 0 clears them all
    task automatic clr();
        rs();
        wr(STATUS_ADDR, 16'h0000);
        st = 16'h0000;
    endtask : clr
    task automatic txp(input int n);
        repeat (n) begin
            @(posedge clk_in);
            tx_item_done_in <= 1'b1;
            @(posedge clk_in);
            tx_item_done_in <= 1'b0;
        end
    endtask : txp
    // =====================================================
    // scenarios
    initial begin
        logic [7:0] d;
        logic [3:0] e;
        d = 8'($urandom(32'h51b7));
        ro_in = sfsf_ro_t'(3'($urandom()));
        ro_bits = {9'h000, ro_in.tx_end, 2'h0, ro_in.framing, ro_in.parity, 2'h0};
        {sys_rst_in, wr_in, rd_in, rx_fifo_full_in, tx_item_done_in} = 5'h10;
        addr_in = '0;
        wr_data_in = '0;
        ext_set_in = '0;
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rs();
        rd(CONTROL_ADDR, 16'h0000);
        rd(8'h0c, 16'h0000);
        wr(STATUS_ADDR, 16'hffff);
        rs();
        wr(CONTROL_ADDR, 16'h0001);
        rd(CONTROL_ADDR, 16'h0001);
        st_q.push_back(sfsf_store_t'({d, 2'h2}));
        sfsf_peer_inst.send(d, 1'b0, 1'b0);
        st[RXERR_BIT] = 1'b1;
        wr(STATUS_ADDR, 16'h0000);
        rs();
        clr();
        rs();
        for (int o = 0; o < 2; o++) begin
            wr(CONTROL_ADDR, {12'h000, o[0], 3'h5});
            d = 8'($urandom());
            st_q.push_back(sfsf_store_t'({d, 2'h0}));
            sfsf_peer_inst.send(d, ^d ^ o[0], 1'b1);
            rs();
            st_q.push_back(sfsf_store_t'({d, 2'h1}));
            sfsf_peer_inst.send(d, ~(^d ^ o[0]), 1'b1);
            st[RXERR_BIT] = 1'b1;
            clr();
        end
        wr(CONTROL_ADDR, 16'h0001);
        rx_fifo_full_in <= 1'b1;
        sfsf_peer_inst.send(d, 1'b0, 1'b1);
        rx_fifo_full_in <= 1'b0;
        st[OVERRUN_BIT] = 1'b1;
        @(negedge clk_in);
        chk({14'h0000, receive_enable_out, overrun_error_flag_out}, 16'h0003);
        wr(CONTROL_ADDR, 16'h0000);
        rs();
        @(negedge clk_in);
        chk({14'h0000, receive_enable_out, overrun_error_flag_out}, 16'h0001);
        wr(CONTROL_ADDR, 16'h0001);
        sfsf_peer_inst.send(d, 1'b0, 1'b1);
        clr();
        st_q.push_back(sfsf_store_t'({d, 2'h0}));
        sfsf_peer_inst.send(d, 1'b0, 1'b1);
        rs();
        wr(CONTROL_ADDR, 16'h0003);
        rx_fifo_full_in <= 1'b1;
        sfsf_peer_inst.send(d, 1'b0, 1'b1);
        rx_fifo_full_in <= 1'b0;
        st_q.push_back(sfsf_store_t'({d, 2'h0}));
        sfsf_peer_inst.send(d, 1'b1, 1'b0);
        rs();
        wr(STOPCNT_ADDR, 16'h0003);
        rd(STOPCNT_ADDR, 16'h0003);
        txp(2);
        rs();
        txp(1);
        st[TXMATCH_BIT] = 1'b1;
        rs();
        clr();
        rs();
        e = 4'($urandom()) | 4'h1;
        ext_set_in <= sfsf_ext_set_t'(e);
        @(posedge clk_in);
        ext_set_in <= '0;
        st = {10'h000, e[3:2], 2'h0, e[1:0]};
        rs();
        wr(STATUS_ADDR, 16'hffff);
        rs();
        clr();
        rs();
        repeat (2) @(posedge clk_in);
        chk(16'(st_q.size()), 16'h0000);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
